//--- ebs_ext_mem.sv
// Behavioural external memory facing the bus cycle sequencer.
// Assumes an active-low read strobe and a 16-bit read bus on clk_in.
`timescale 1ns/1ns
`default_nettype none
module ebs_ext_mem
import ebs_pkg::*;
(
    input wire logic clk_in,
    input wire logic rd_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    output logic [DATA_W-1:0] data_out
);
    logic [DATA_W-1:0] last_ff = 16'h0000;
    // Last driven word, so a released bus never repeats it
    always_ff @(posedge clk_in)
    begin
        if (!rd_n_in)
            last_ff <= data_out;
    end
    // Word valid until the strobe rises, inverse once released
    assign data_out = !rd_n_in ? (addr_in[15:0] ^ 16'h5a3c) : ~last_ff;
endmodule
`default_nettype wire

//--- ebs_fifo.sv
// Request FIFO in front of the phase sequencer.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module ebs_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ff;
    logic [PW-1:0] rd_ff;
    logic [PW:0] cnt_ff;
    logic push;
    logic pop;

    // Honest flags straight from the count
    assign in_ready_out = (cnt_ff != DEPTH[PW:0]);
    assign out_valid_out = (cnt_ff != '0);
    assign out_data_out = mem[rd_ff];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // Storage needs no reset
    always_ff @(posedge clk_in)
    begin
        if (push)
            mem[wr_ff] <= in_data_in;
    end

    // Pointers wrap because depth is a power of two
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (push)
                wr_ff <= wr_ff + 1'b1;
            if (pop)
                rd_ff <= rd_ff + 1'b1;
            if (push && !pop)
                cnt_ff <= cnt_ff + 1'b1;
            else if (pop && !push)
                cnt_ff <= cnt_ff - 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- ebs_pkg.sv
// Package for the external bus cycle phase sequencer.
// Assumes one clock at the CPU rate; one phase tick is one clock period.
package ebs_pkg;
    // Timing configuration field layout (per chip select)
    localparam int AB_POS = 0;
    localparam int AB_W = 1;
    localparam int C_POS = 1;
    localparam int C_W = 2;
    localparam int D_POS = 3;
    localparam int E_POS = 4;
    localparam int E_W = 5;
    localparam int F_POS = 9;
    localparam int F_W = 2;
    localparam int EXT_POS = 11;
    localparam int EXT_W = 2;
    localparam int CFG_W = 13;
    localparam int NUM_CS = 4;
    localparam int CS_W = 2;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int REQ_W = 45;
    localparam int FIFO_DEPTH = 4;
    localparam int CNT_W = 5;
    // Reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
    localparam logic [CS_W-1:0] CS_RST = 2'h0;

    typedef enum logic [5:0] {
        EBS_IDLE = 6'h01,
        EBS_AB = 6'h02,
        EBS_C = 6'h04,
        EBS_D = 6'h08,
        EBS_E = 6'h10,
        EBS_F = 6'h20
    } ebs_phase_type;
endpackage

//--- ebs_sequencer.sv
// External bus cycle phase sequencer: requests queue in a FIFO, then each
// cycle runs address setup, command delay if nonzero, data setup if enabled, access, hold if nonzero.
// Assumes requests and read data are synchronous to clk_in.
`timescale 1ns/1ns
`default_nettype none
module ebs_sequencer
import ebs_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [NUM_CS*CFG_W-1:0] chip_select_timing_config_in,
    input wire logic mux_mode_in,
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire logic [CS_W-1:0] req_cs_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic req_write_in,
    input wire logic [1:0] req_be_in,
    input wire logic [DATA_W-1:0] req_wdata_in,
    output logic rsp_valid_out,
    output logic [DATA_W-1:0] rsp_rdata_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic ale_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic high_byte_enable_n_out,
    output logic [NUM_CS-1:0] cs_n_out,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_out,
    output logic busy_out
);
    typedef struct packed {
        ebs_phase_type phase;
        logic [CNT_W-1:0] cnt;
        logic [CFG_W-1:0] cfg;
        logic [CS_W-1:0] cs;
        logic [CS_W-1:0] last_cs;
        logic have_last;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic ale;
        logic rd_n;
        logic wr_n;
        logic hi_en_n;
        logic [NUM_CS-1:0] cs_n;
        logic oe;
        logic [DATA_W-1:0] dout;
        logic rsp;
        logic [DATA_W-1:0] rdata;
        logic busy;
    } ebs_state_type;

    ebs_state_type st_ff;
    ebs_state_type nxt_st;
    logic q_valid;
    logic q_take;
    logic [REQ_W-1:0] q_data;
    logic [REQ_W-1:0] in_word;

    // Checks share the core clock and are muted during reset
    default clocking ebs_cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // Config field extract, used once when a cycle leaves idle
    function automatic logic [CFG_W-1:0] cfg_of(
        input logic [NUM_CS*CFG_W-1:0] all,
        input logic [CS_W-1:0] sel
    );
        cfg_of = all[sel*CFG_W +: CFG_W];
    endfunction

    // Depth-4 queue decouples the CPU from long external cycles
    assign in_word = {req_cs_in, req_addr_in, req_write_in, req_be_in,
        req_wdata_in};
    ebs_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .in_valid_in(req_valid_in),
        .in_ready_out(req_ready_out),
        .in_data_in(in_word),
        .out_valid_out(q_valid),
        .out_ready_in(q_take),
        .out_data_out(q_data)
    );
    assign q_take = (st_ff.phase == EBS_IDLE) && q_valid;

    // Next-state logic for the whole cycle
    always_comb
    begin
        logic [CNT_W-1:0] ab_len;
        logic [CFG_W-1:0] c;
        logic [CS_W-1:0] ncs;
        logic [CNT_W-1:0] len_c;
        logic [CNT_W-1:0] len_f;
        logic to_d;
        logic to_e;
        logic to_idle;
        ab_len = CNT_RST;
        len_c = CNT_W'(st_ff.cfg[C_POS +: C_W]);
        len_f = CNT_W'(st_ff.cfg[F_POS +: F_W]);
        to_d = 1'b0;
        to_e = 1'b0;
        to_idle = 1'b0;
        c = cfg_of(chip_select_timing_config_in, q_data[REQ_W-1 -: CS_W]);
        ncs = q_data[REQ_W-1 -: CS_W];
        nxt_st = st_ff;
        nxt_st.rsp = 1'b0;
        unique case (st_ff.phase)
            EBS_IDLE:
            begin
                if (q_valid)
                begin
                    // Latch config once per cycle so mid-cycle edits are safe
                    nxt_st.cfg = c;
                    nxt_st.cs = ncs;
                    nxt_st.addr = q_data[DATA_W+3 +: ADDR_W];
                    nxt_st.write = q_data[DATA_W+2];
                    nxt_st.hi_en_n = ~q_data[DATA_W+1];
                    nxt_st.wdata = q_data[DATA_W-1:0];
                    ab_len = CNT_W'(c[AB_POS +: AB_W]) + 5'h01;
                    if (st_ff.have_last && st_ff.last_cs != ncs)
                        ab_len = ab_len + CNT_W'(c[EXT_POS +: EXT_W]);
                    nxt_st.cnt = ab_len - 5'h01;
                    nxt_st.phase = EBS_AB;
                    nxt_st.ale = 1'b1;
                    nxt_st.cs_n = ~(NUM_CS'(1) << ncs);
                    nxt_st.oe = mux_mode_in;
                    nxt_st.dout = mux_mode_in ?
                        q_data[DATA_W+3 +: DATA_W] : DATA_RST;
                    nxt_st.last_cs = ncs;
                    nxt_st.have_last = 1'b1;
                    nxt_st.busy = 1'b1;
                end
            end
            EBS_AB:
            begin
                if (st_ff.cnt != CNT_RST)
                    nxt_st.cnt = st_ff.cnt - 5'h01;
                else
                begin
                    nxt_st.ale = 1'b0;
                    nxt_st.oe = 1'b0;
                    // A zero command delay skips the phase entirely
                    if (len_c != CNT_RST)
                    begin
                        nxt_st.phase = EBS_C;
                        nxt_st.cnt = len_c - 5'h01;
                    end
                    else
                        to_d = 1'b1;
                end
            end
            EBS_C:
            begin
                if (st_ff.cnt != CNT_RST)
                    nxt_st.cnt = st_ff.cnt - 5'h01;
                else
                    to_d = 1'b1;
            end
            // Setup phase is always exactly one period
            EBS_D:
                to_e = 1'b1;
            EBS_E:
            begin
                if (st_ff.cnt != CNT_RST)
                    nxt_st.cnt = st_ff.cnt - 5'h01;
                else
                begin
                    // Capture on the edge that releases the strobe
                    if (!st_ff.write)
                    begin
                        nxt_st.rdata = data_in;
                        nxt_st.rsp = 1'b1;
                    end
                    nxt_st.rd_n = 1'b1;
                    nxt_st.wr_n = 1'b1;
                    // A zero hold ends the cycle on this same edge
                    if (len_f != CNT_RST)
                    begin
                        nxt_st.phase = EBS_F;
                        nxt_st.cnt = len_f - 5'h01;
                    end
                    else
                        to_idle = 1'b1;
                end
            end
            EBS_F:
            begin
                if (st_ff.cnt != CNT_RST)
                    nxt_st.cnt = st_ff.cnt - 5'h01;
                else
                    to_idle = 1'b1;
            end
            default:
                to_idle = 1'b1;
        endcase
        // Shared phase entries, so zero-length phases fall through
        if (to_d && st_ff.cfg[D_POS])
        begin
            // Write data setup or mux turnaround, one period
            nxt_st.phase = EBS_D;
            nxt_st.oe = st_ff.write;
            nxt_st.dout = st_ff.wdata;
        end
        else if (to_d || to_e)
        begin
            nxt_st.phase = EBS_E;
            nxt_st.cnt = CNT_W'(st_ff.cfg[E_POS +: E_W]);
            nxt_st.rd_n = st_ff.write;
            nxt_st.wr_n = ~st_ff.write;
            nxt_st.oe = st_ff.write;
            nxt_st.dout = st_ff.wdata;
        end
        if (to_idle)
        begin
            nxt_st.phase = EBS_IDLE;
            nxt_st.busy = 1'b0;
            nxt_st.oe = 1'b0;
            nxt_st.cs_n = '1;
            if (st_ff.write)
                nxt_st.rsp = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_ff.phase <= EBS_IDLE;
            st_ff.cnt <= CNT_RST;
            st_ff.cfg <= '0;
            st_ff.cs <= CS_RST;
            st_ff.last_cs <= CS_RST;
            st_ff.have_last <= 1'b0;
            st_ff.write <= 1'b0;
            st_ff.addr <= ADDR_RST;
            st_ff.wdata <= DATA_RST;
            st_ff.ale <= 1'b0;
            st_ff.rd_n <= 1'b1;
            st_ff.wr_n <= 1'b1;
            st_ff.hi_en_n <= 1'b1;
            st_ff.cs_n <= '1;
            st_ff.oe <= 1'b0;
            st_ff.dout <= DATA_RST;
            st_ff.rsp <= 1'b0;
            st_ff.rdata <= DATA_RST;
            st_ff.busy <= 1'b0;
        end
        else
            st_ff <= nxt_st;
    end

    assign addr_out = st_ff.addr;
    assign ale_out = st_ff.ale;
    assign rd_n_out = st_ff.rd_n;
    assign wr_n_out = st_ff.wr_n;
    assign high_byte_enable_n_out = st_ff.hi_en_n;
    assign cs_n_out = st_ff.cs_n;
    assign data_out = st_ff.dout;
    assign data_oe_out = st_ff.oe;
    assign rsp_valid_out = st_ff.rsp;
    assign rsp_rdata_out = st_ff.rdata;
    assign busy_out = st_ff.busy;

    // Cycle length counter, for checking only
    logic [6:0] len_ff;
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            len_ff <= 7'h00;
        else if (st_ff.phase == EBS_IDLE)
            len_ff <= 7'h00;
        else
            len_ff <= len_ff + 7'h01;
    end

    a_phase_order: assert property (st_ff.phase == EBS_AB &&
        nxt_st.phase != EBS_AB |-> nxt_st.phase inside {EBS_C, EBS_D, EBS_E})
        else $error("address setup not followed by a later phase");
    a_c_order: assert property (st_ff.phase == EBS_C &&
        nxt_st.phase != EBS_C |-> nxt_st.phase inside {EBS_D, EBS_E})
        else $error("command delay not followed by setup or access");
    a_e_exit: assert property (st_ff.phase == EBS_E &&
        nxt_st.phase != EBS_E |-> nxt_st.phase inside {EBS_F, EBS_IDLE})
        else $error("access not followed by hold or idle");
    a_d_len: assert property (st_ff.phase == EBS_D |->
        nxt_st.phase == EBS_E)
        else $error("data setup longer than one period");
    a_ab_len: assert property (st_ff.phase == EBS_IDLE &&
        nxt_st.phase == EBS_AB |-> nxt_st.cnt <= 5'h04)
        else $error("address setup too long");
    a_access_strobe: assert property (st_ff.phase == EBS_E |->
        st_ff.rd_n != st_ff.wr_n)
        else $error("no strobe in access phase");
    a_read_capture: assert property ($rose(st_ff.rd_n) |->
        st_ff.rsp && st_ff.rdata == $past(data_in))
        else $error("read data not latched at strobe rise");
    a_c_len: assert property (st_ff.phase == EBS_C |->
        st_ff.cnt <= 5'h02)
        else $error("command delay too long");
    a_f_len: assert property (st_ff.phase == EBS_F |->
        st_ff.cnt <= 5'h02)
        else $error("hold too long");
    a_cfg_hold: assert property (st_ff.phase != EBS_IDLE &&
        $past(st_ff.phase) != EBS_IDLE |-> $stable(st_ff.cfg))
        else $error("config changed mid cycle");
    a_total_len: assert property (st_ff.phase != EBS_IDLE |->
        len_ff <= 7'h2b)
        else $error("cycle longer than phase sum bound");
    a_busy_window: assert property (st_ff.busy == (st_ff.cs_n != '1))
        else $error("busy flag disagrees with chip select window");
    c_read: cover property ($rose(st_ff.rd_n));
    c_write: cover property ($rose(st_ff.wr_n));
    c_d_phase: cover property (st_ff.phase == EBS_D);
    c_window_ext: cover property (st_ff.phase == EBS_AB && st_ff.cnt == 5'h04);
    c_mux_addr: cover property (st_ff.ale && st_ff.oe);
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the bus cycle phase sequencer.
// Assumes the external memory model answers every read.
`timescale 1ns/1ns
`default_nettype none
module tb
import ebs_pkg::*;
;
    typedef struct {int len; int ale; int pos; int e; logic [3:0] csn;
        logic [17:0] wd; logic [17:0] ab; logic [23:0] ad;} ebs_cyc_type;
    logic clk_in = 0;
    logic rst_in = 1;
    logic [NUM_CS*CFG_W-1:0] cfg;
    logic mux, req_valid, req_write, req_ready, rsp_valid, ale, rd_n, wr_n;
    logic hbe_n, oe, busy;
    logic [1:0] req_cs, req_be;
    logic [ADDR_W-1:0] req_addr, addr;
    logic [DATA_W-1:0] req_wdata, rdata, din, dout;
    logic [3:0] cs_n;
    logic [31:0] lfsr = 32'hb784c0be;
    logic [31:0] s;
    logic [1:0] prev_cs;
    int err_total, samples_checked, cycles, n, an, sp, sn, b, i, k;
    bit have_prev;
    ebs_cyc_type cyc_q[$];
    ebs_cyc_type cur;
    logic [16:0] rsp_q[$];
    logic [16:0] r;

    ebs_sequencer dut_u (.clk_in(clk_in), .rst_in(rst_in),
        .chip_select_timing_config_in(cfg), .mux_mode_in(mux),
        .req_valid_in(req_valid), .req_ready_out(req_ready),
        .req_cs_in(req_cs), .req_addr_in(req_addr),
        .req_write_in(req_write), .req_be_in(req_be),
        .req_wdata_in(req_wdata), .rsp_valid_out(rsp_valid),
        .rsp_rdata_out(rdata), .addr_out(addr), .ale_out(ale),
        .rd_n_out(rd_n), .wr_n_out(wr_n), .high_byte_enable_n_out(hbe_n),
        .cs_n_out(cs_n), .data_in(din), .data_out(dout),
        .data_oe_out(oe), .busy_out(busy));
    ebs_ext_mem mem_u (.clk_in(clk_in), .rd_n_in(rd_n), .addr_in(addr),
        .data_out(din));

    always #4 clk_in = ~clk_in;

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        if (err_total == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Note the expected phase counts, then hold the request until taken
    task automatic send(input logic [1:0] cs, input logic w);
        ebs_cyc_type c;
        logic [12:0] f;
        logic [31:0] v;
        int t;
        v = rnd();
        f = cfg[cs*CFG_W +: CFG_W];
        c.ale = f[0] + 1 + ((have_prev && cs != prev_cs) ? f[12:11] : 0);
        c.pos = c.ale + f[2:1] + f[3];
        c.e = f[8:4] + 1;
        c.len = c.pos + c.e + f[10:9];
        c.csn = ~(4'h1 << cs);
        c.wd = {1'b1, ~v[26], v[15:0]};
        c.ab = {mux, ~v[26], mux ? v[15:0] : DATA_RST};
        c.ad = {v[31:24], v[15:0]};
        have_prev = 1;
        prev_cs = cs;
        cyc_q.push_back(c);
        rsp_q.push_back({w, v[15:0] ^ 16'h5a3c});
        @(negedge clk_in);
        req_cs = cs;
        req_write = w;
        req_addr = {v[31:24], v[15:0]};
        req_be = v[26:25];
        req_wdata = v[15:0];
        req_valid = 1;
        t = 0;
        do
            @(posedge clk_in);
        while (!req_ready && ++t < 500);
    endtask

    // Watch each chip-select window and each response pulse
    always @(posedge clk_in)
    begin
        if (!rst_in)
            check(busy, cs_n != 4'hf);
        if (!rst_in && cs_n != 4'hf)
        begin
            if (n == 0)
                cur = cyc_q.pop_front();
            if (n == 0)
                check(cs_n, cur.csn);
            if (n == 0)
                check(addr, cur.ad);
            if (n == 0)
                check({oe, hbe_n, dout}, cur.ab);
            n++;
            if (ale)
                an++;
            if (!(rd_n && wr_n))
            begin
                if (sn == 0)
                    sp = n - 1;
                sn++;
            end
            if (!wr_n)
                check({oe, hbe_n, dout}, cur.wd);
        end
        else if (n != 0)
        begin
            check(n, cur.len);
            check(an, cur.ale);
            check(sp, cur.pos);
            check(sn, cur.e);
            n = 0;
            an = 0;
            sn = 0;
        end
        if (rsp_valid)
        begin
            r = rsp_q.pop_front();
            if (!r[16])
                check(rdata, r[15:0]);
        end
    end

    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            print_verdict;
        end
    end

    initial
    begin
        cfg = '0;
        mux = 0;
        req_valid = 0;
        req_cs = 0;
        req_addr = 0;
        req_write = 0;
        req_be = 0;
        req_wdata = 0;
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 0;
        // Batch 0 shortest phases, batch 1 longest, the rest random
        for (b = 0; b < 12; b++)
        begin
            @(negedge clk_in);
            s = rnd();
            cfg[31:0] = s;
            s = rnd();
            cfg[51:32] = s[19:0];
            mux = s[31];
            if (b < 2)
                cfg = b ? '1 : '0;
            // Six back to back requests overfill the four-word queue
            for (i = 0; i < 6; i++)
            begin
                s = rnd();
                send(s[1:0], s[2]);
            end
            @(negedge clk_in);
            req_valid = 0;
            k = 0;
            while ((cyc_q.size() != 0 || rsp_q.size() != 0) && k++ < 3000)
                @(posedge clk_in);
            repeat (3) @(posedge clk_in);
            check(cyc_q.size() + rsp_q.size(), 0);
        end
        print_verdict;
    end
endmodule
`default_nettype wire
